/* include/sppf_params.svh */
// register map, reset values, characters and timing counts of the controller
`ifndef SPPF_PARAMS_SVH
`define SPPF_PARAMS_SVH
// ==========================================================
// register offsets (byte addresses, one word each)
`define SPPF_OFF_CTRL 8'h00
`define SPPF_OFF_IDS 8'h04
`define SPPF_OFF_BAUD 8'h08
`define SPPF_OFF_RESP 8'h0C
`define SPPF_OFF_TXD 8'h10
`define SPPF_OFF_RXD 8'h14
`define SPPF_OFF_STAT 8'h18
// ==========================================================
// reset values
`define SPPF_CTRL_RST 7'h30
`define SPPF_IDS_RST 32'hFFFFFFFF
`define SPPF_BAUD_RST 16'h043C
`define SPPF_RESP_RST 32'h00010000
// ==========================================================
// status bit positions
`define SPPF_ST_OK 0
`define SPPF_ST_FAIL 1
`define SPPF_ST_RANGE 2
`define SPPF_ST_LEN 3
`define SPPF_ST_OVR 4
`define SPPF_ST_YIELD 5
// ==========================================================
// protocol characters and limits
`define SPPF_STX 8'h02
`define SPPF_ETX 8'h03
`define SPPF_DLE 8'h10
`define SPPF_NAK 8'h15
`define SPPF_USS_STX 8'h02
`define SPPF_ID_MIN 8'h01
`define SPPF_ID_MAX 8'h1F
`define SPPF_PAY_MIN 8'h20
`define SPPF_PAY_MAX6 8'h3F
`define SPPF_PAY_MAX7 8'h7F
`define SPPF_MAX_3964 8'hFF
`define SPPF_USS_BC_BIT 5
`define SPPF_USS_ADR_IDX 8'h01
`define SPPF_MB_ADR_IDX 8'h00
`define SPPF_MB_BCAST 8'h00
`define SPPF_W6 2'h1
`define SPPF_W7 2'h2
`define SPPF_W8 2'h3
// ==========================================================
// frame slot indices and serial bit counts
`define SPPF_SLOT_2 2'h2
`define SPPF_SLOT_END 2'h3
`define SPPF_TX_BITS 4'hB
`define SPPF_RX_BITS 4'hA
`define SPPF_LAST_BIT 4'h1
`endif

/* include/sppf_pkg.sv */
// types shared by the serial partner controller
package sppf_pkg;
  typedef enum logic [2:0] {
    SPPF_RAW, SPPF_IDS, SPPF_R3964, SPPF_USS, SPPF_MODBUS
  } sppf_mode_type;
  typedef enum logic [2:0] {
    SQ_IDLE, SQ_PRE, SQ_CONN, SQ_DATA, SQ_POST, SQ_ACK, SQ_DROP
  } sppf_seq_type;
endpackage : sppf_pkg

/* core/sppf_host_ctrl.sv */
// serial partner controller: apb registers, framing sequencer, uart line
//
// Our own choices: the APB interface to the registers and the register offsets.
`include "sppf_params.svh"
module sppf_host_ctrl
  import sppf_pkg::*;
(
  // clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pce,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // half-duplex serial line
  input wire logic line_in,
  output logic line_out,
  output logic line_oe_n,
  output logic rts
);
  // ==========================================================
  // declarations
  logic [6:0] ctrl_reg, ctrl_next;
  logic [31:0] ids_reg, ids_next, resp_reg, resp_next;
  logic [15:0] baud_reg, baud_next;
  logic [5:0] stat_reg, stat_next;
  logic [7:0] txh_reg, txh_next, rxd_reg, rxd_next;
  logic txh_last_reg, txh_last_next, txh_vld_reg, txh_vld_next;
  logic rxd_vld_reg, rxd_vld_next;
  logic [31:0] prdata_reg, prdata_next, rd_word;
  logic pready_reg, pready_next, pslverr_reg, pslverr_next, mapped;
  sppf_seq_type seq_reg, seq_next;
  logic [1:0] idx_reg, idx_next;
  logic [7:0] cnt_reg, cnt_next, bcc_reg, bcc_next, send_byte;
  logic bcast_reg, bcast_next, dup_reg, dup_next;
  logic [31:0] tmr_reg, tmr_next;
  logic [9:0] tx_sh_reg, tx_sh_next;
  logic [3:0] tx_bits_reg, tx_bits_next;
  logic [15:0] tx_div_reg, tx_div_next;
  logic line_out_reg, line_out_next, line_oe_n_reg, line_oe_n_next;
  logic rts_reg, rts_next;
  logic sync1_reg, sync2_reg;
  logic [3:0] rx_bits_reg, rx_bits_next;
  logic [15:0] rx_div_reg, rx_div_next;
  logic [7:0] rx_sh_reg, rx_sh_next, rx_byte_reg, rx_byte_next;
  logic rx_pulse_reg, rx_pulse_next;
  logic send, txh_take, tx_idle, busy, access, done;
  logic ev_ok, ev_fail, ev_range, ev_len, ev_yield;
  logic [8:0] slot;
  sppf_mode_type mode;

  assign mode = sppf_mode_type'(ctrl_reg[2:0]);
  assign tx_idle = (tx_bits_reg == 4'h0);
  assign busy = (seq_reg != SQ_IDLE) || !tx_idle;
  assign access = psel && penable;
  assign done = access && pready_reg;
  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign line_out = line_out_reg;
  assign line_oe_n = line_oe_n_reg;
  assign rts = rts_reg;

  // ==========================================================
  // helpers
  // control character, identifier or block check character for a prefix or suffix slot
  function automatic logic [8:0] frame_slot(input sppf_mode_type m,
      input logic post, input logic [1:0] i, input logic [31:0] ids,
      input logic [7:0] bcc);
    logic [7:0] id;
    frame_slot = 9'h000;
    id = post ? (i[0] ? ids[31:24] : ids[23:16])
              : (i[0] ? ids[15:8] : ids[7:0]);
    case (m)
      SPPF_IDS: begin
        // FFh or anything above 1Fh leaves the slot empty
        if (!i[1] && id >= `SPPF_ID_MIN && id <= `SPPF_ID_MAX) begin
          frame_slot = {1'b1, id};
        end
      end
      SPPF_R3964: begin
        if (!post && i == 2'h0) begin
          frame_slot = {1'b1, `SPPF_STX};
        end else if (post && i == 2'h0) begin
          frame_slot = {1'b1, `SPPF_DLE};
        end else if (post && i == 2'h1) begin
          frame_slot = {1'b1, `SPPF_ETX};
        end else if (post && i == `SPPF_SLOT_2) begin
          frame_slot = {1'b1, bcc};
        end
      end
      SPPF_USS: begin
        if (!post && i == 2'h0) begin
          frame_slot = {1'b1, `SPPF_USS_STX};
        end else if (post && i == 2'h0) begin
          frame_slot = {1'b1, bcc};
        end
      end
      default: frame_slot = 9'h000;
    endcase
  endfunction : frame_slot

  // payload character allowed for the configured character width
  function automatic logic pay_ok(input logic [1:0] w, input logic [7:0] b);
    pay_ok = (b >= `SPPF_PAY_MIN) && ((w == `SPPF_W8) ||
             (w == `SPPF_W7 && b <= `SPPF_PAY_MAX7) ||
             (w == `SPPF_W6 && b <= `SPPF_PAY_MAX6));
  endfunction : pay_ok

  // ==========================================================
  // apb registers: next values
  always_comb begin
    ctrl_next = ctrl_reg;
    ids_next = ids_reg;
    baud_next = baud_reg;
    resp_next = resp_reg;
    txh_next = txh_reg;
    txh_last_next = txh_last_reg;
    txh_vld_next = txh_vld_reg && !txh_take;
    rxd_next = rxd_reg;
    rxd_vld_next = rxd_vld_reg;
    prdata_next = prdata_reg;
    pready_next = 1'b0;
    pslverr_next = 1'b0;
    stat_next = stat_reg;
    mapped = 1'b1;
    rd_word = 32'h00000000;
    case (paddr)
      `SPPF_OFF_CTRL: rd_word = {25'h0000000, ctrl_reg};
      `SPPF_OFF_IDS: rd_word = ids_reg;
      `SPPF_OFF_BAUD: rd_word = {16'h0000, baud_reg};
      `SPPF_OFF_RESP: rd_word = resp_reg;
      `SPPF_OFF_TXD: rd_word = {23'h000000, txh_vld_reg, txh_reg};
      `SPPF_OFF_RXD: rd_word = {23'h000000, rxd_vld_reg, rxd_reg};
      `SPPF_OFF_STAT: rd_word = {22'h000000, !txh_vld_reg, busy, 2'h0,
                                 stat_reg};
      default: mapped = 1'b0;
    endcase
    // first access cycle: latch answer, complete one cycle later
    if (access && !pready_reg) begin
      pready_next = 1'b1;
      prdata_next = rd_word;
      pslverr_next = !mapped || (pwrite && paddr == `SPPF_OFF_RXD) ||
                     (pwrite && paddr == `SPPF_OFF_TXD && txh_vld_reg);
    end
    if (done && pwrite && !pslverr_reg) begin
      case (paddr)
        `SPPF_OFF_CTRL: ctrl_next = pwdata[6:0];
        `SPPF_OFF_IDS: ids_next = pwdata;
        `SPPF_OFF_BAUD: baud_next = pwdata[15:0];
        `SPPF_OFF_RESP: resp_next = pwdata;
        `SPPF_OFF_TXD: begin
          txh_next = pwdata[7:0];
          txh_last_next = pwdata[8];
          txh_vld_next = 1'b1;
        end
        `SPPF_OFF_STAT: stat_next = stat_reg & ~pwdata[5:0];
        default: stat_next = stat_reg;
      endcase
    end
    if (done && !pwrite && paddr == `SPPF_OFF_RXD) begin
      rxd_vld_next = 1'b0;
    end
    // a new byte beats the pop of the old one
    if (rx_pulse_reg) begin
      rxd_next = rx_byte_reg;
      rxd_vld_next = 1'b1;
      stat_next[`SPPF_ST_OVR] = stat_next[`SPPF_ST_OVR] | (rxd_vld_reg &&
        !(done && !pwrite && paddr == `SPPF_OFF_RXD));
    end
    // events win over a clear in the same cycle
    stat_next[`SPPF_ST_OK] = stat_next[`SPPF_ST_OK] | ev_ok;
    stat_next[`SPPF_ST_FAIL] = stat_next[`SPPF_ST_FAIL] | ev_fail;
    stat_next[`SPPF_ST_RANGE] = stat_next[`SPPF_ST_RANGE] | ev_range;
    stat_next[`SPPF_ST_LEN] = stat_next[`SPPF_ST_LEN] | ev_len;
    stat_next[`SPPF_ST_YIELD] = stat_next[`SPPF_ST_YIELD] | ev_yield;
  end

  // apb registers: storage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= `SPPF_CTRL_RST;
      ids_reg <= `SPPF_IDS_RST;
      baud_reg <= `SPPF_BAUD_RST;
      resp_reg <= `SPPF_RESP_RST;
      txh_reg <= 8'h00;
      txh_last_reg <= 1'b0;
      txh_vld_reg <= 1'b0;
      rxd_reg <= 8'h00;
      rxd_vld_reg <= 1'b0;
      prdata_reg <= 32'h00000000;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      stat_reg <= 6'h00;
    end else if (pce) begin
      ctrl_reg <= ctrl_next;
      ids_reg <= ids_next;
      baud_reg <= baud_next;
      resp_reg <= resp_next;
      txh_reg <= txh_next;
      txh_last_reg <= txh_last_next;
      txh_vld_reg <= txh_vld_next;
      rxd_reg <= rxd_next;
      rxd_vld_reg <= rxd_vld_next;
      prdata_reg <= prdata_next;
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
      stat_reg <= stat_next;
    end
  end

  // ==========================================================
  // framing sequencer and uart transmitter: next values
  always_comb begin
    seq_next = seq_reg;
    idx_next = idx_reg;
    cnt_next = cnt_reg;
    bcc_next = bcc_reg;
    bcast_next = bcast_reg;
    dup_next = dup_reg;
    tmr_next = tmr_reg;
    tx_sh_next = tx_sh_reg;
    tx_bits_next = tx_bits_reg;
    tx_div_next = tx_div_reg;
    line_out_next = line_out_reg;
    line_oe_n_next = line_oe_n_reg;
    rts_next = rts_reg;
    txh_take = 1'b0;
    send = 1'b0;
    send_byte = 8'h00;
    ev_ok = 1'b0;
    ev_fail = 1'b0;
    ev_range = 1'b0;
    ev_len = 1'b0;
    ev_yield = 1'b0;
    slot = frame_slot(mode, seq_reg == SQ_POST, idx_reg, ids_reg, bcc_reg);
    // bit shifter; driver released when the stop bit ends
    if (!tx_idle) begin
      if (tx_div_reg == 16'h0000) begin
        tx_div_next = baud_reg;
        line_out_next = tx_sh_reg[0];
        tx_sh_next = {1'b1, tx_sh_reg[9:1]};
        tx_bits_next = tx_bits_reg - 4'h1;
        if (tx_bits_reg == `SPPF_LAST_BIT) begin
          line_oe_n_next = 1'b1;
          rts_next = 1'b0;
        end
      end else begin
        tx_div_next = tx_div_reg - 16'h0001;
      end
    end
    unique case (seq_reg)
      SQ_IDLE: begin
        if (txh_vld_reg && tx_idle) begin
          seq_next = SQ_PRE;
          idx_next = 2'h0;
          cnt_next = 8'h00;
          bcc_next = 8'h00;
          bcast_next = 1'b0;
          dup_next = 1'b0;
        end
      end
      SQ_PRE, SQ_POST: begin
        if (tx_idle && idx_reg == `SPPF_SLOT_END) begin
          tmr_next = resp_reg;
          idx_next = 2'h0;
          if (seq_reg == SQ_PRE) begin
            seq_next = (mode == SPPF_R3964) ? SQ_CONN : SQ_DATA;
          end else if ((mode == SPPF_R3964 || mode == SPPF_USS ||
                        mode == SPPF_MODBUS) && !bcast_reg) begin
            seq_next = SQ_ACK;
          end else begin
            seq_next = SQ_IDLE;
          end
        end else if (tx_idle) begin
          idx_next = idx_reg + 2'h1;
          send = slot[8];
          send_byte = slot[7:0];
        end
      end
      SQ_CONN: begin
        if (rx_pulse_reg && rx_byte_reg == `SPPF_DLE) begin
          seq_next = SQ_DATA;
        end else if (rx_pulse_reg && rx_byte_reg == `SPPF_STX &&
                     !ctrl_reg[6]) begin
          ev_yield = 1'b1;
          seq_next = SQ_IDLE;
        end else if (rx_pulse_reg || tmr_reg == 32'h00000000) begin
          ev_fail = 1'b1;
          seq_next = SQ_DROP;
        end else begin
          tmr_next = tmr_reg - 32'h00000001;
        end
      end
      SQ_DATA: begin
        if (txh_vld_reg && tx_idle) begin
          if (mode == SPPF_IDS && !pay_ok(ctrl_reg[5:4], txh_reg)) begin
            ev_range = 1'b1;
            txh_take = 1'b1;
          end else if (mode == SPPF_R3964 && cnt_reg == `SPPF_MAX_3964) begin
            ev_len = 1'b1;
            seq_next = SQ_DROP;
          end else begin
            send = 1'b1;
            send_byte = txh_reg;
            if (mode == SPPF_R3964 && txh_reg == `SPPF_DLE && !dup_reg) begin
              dup_next = 1'b1;
            end else begin
              dup_next = 1'b0;
              txh_take = 1'b1;
              cnt_next = cnt_reg + 8'h01;
              if (mode == SPPF_USS && cnt_reg == `SPPF_USS_ADR_IDX &&
                  txh_reg[`SPPF_USS_BC_BIT]) begin
                bcast_next = 1'b1;
              end
              if (mode == SPPF_MODBUS && cnt_reg == `SPPF_MB_ADR_IDX &&
                  txh_reg == `SPPF_MB_BCAST) begin
                bcast_next = 1'b1;
              end
            end
          end
          if (txh_take && txh_last_reg) begin
            seq_next = SQ_POST;
          end
        end
      end
      SQ_ACK: begin
        // no new frame while waiting for this answer
        if (rx_pulse_reg) begin
          seq_next = SQ_IDLE;
          if (mode == SPPF_R3964) begin
            ev_ok = (rx_byte_reg == `SPPF_DLE);
            ev_fail = (rx_byte_reg != `SPPF_DLE);
          end else if (mode == SPPF_USS) begin
            ev_ok = (rx_byte_reg == `SPPF_USS_STX);
            ev_fail = (rx_byte_reg != `SPPF_USS_STX);
          end else begin
            ev_ok = 1'b1;
          end
        end else if (tmr_reg == 32'h00000000) begin
          ev_fail = 1'b1;
          seq_next = SQ_IDLE;
        end else begin
          tmr_next = tmr_reg - 32'h00000001;
        end
      end
      SQ_DROP: begin
        if (txh_vld_reg) begin
          txh_take = 1'b1;
          if (txh_last_reg) begin
            seq_next = SQ_IDLE;
          end
        end
      end
    endcase
    if (send) begin
      // bcc skips the 3964R start character
      if (!(seq_reg == SQ_PRE && mode != SPPF_USS)) begin
        bcc_next = bcc_reg ^ send_byte;
      end
      tx_sh_next = {1'b1, send_byte, 1'b0};
      tx_bits_next = `SPPF_TX_BITS;
      tx_div_next = 16'h0000;
      line_oe_n_next = 1'b0;
      rts_next = 1'b1;
    end
  end

  // framing sequencer and uart transmitter: storage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seq_reg <= SQ_IDLE;
      idx_reg <= 2'h0;
      cnt_reg <= 8'h00;
      bcc_reg <= 8'h00;
      bcast_reg <= 1'b0;
      dup_reg <= 1'b0;
      tmr_reg <= 32'h00000000;
      tx_sh_reg <= 10'h3FF;
      tx_bits_reg <= 4'h0;
      tx_div_reg <= 16'h0000;
      line_out_reg <= 1'b1;
      line_oe_n_reg <= 1'b1;
      rts_reg <= 1'b0;
    end else if (pce) begin
      seq_reg <= seq_next;
      idx_reg <= idx_next;
      cnt_reg <= cnt_next;
      bcc_reg <= bcc_next;
      bcast_reg <= bcast_next;
      dup_reg <= dup_next;
      tmr_reg <= tmr_next;
      tx_sh_reg <= tx_sh_next;
      tx_bits_reg <= tx_bits_next;
      tx_div_reg <= tx_div_next;
      line_out_reg <= line_out_next;
      line_oe_n_reg <= line_oe_n_next;
      rts_reg <= rts_next;
    end
  end

  // ==========================================================
  // uart receiver, ignores the line while driving it: next values
  always_comb begin
    rx_bits_next = rx_bits_reg;
    rx_div_next = rx_div_reg;
    rx_sh_next = rx_sh_reg;
    rx_byte_next = rx_byte_reg;
    rx_pulse_next = 1'b0;
    if (rx_bits_reg == 4'h0) begin
      if (!sync2_reg && line_oe_n_reg) begin
        rx_bits_next = `SPPF_RX_BITS;
        rx_div_next = baud_reg >> 1;
      end
    end else if (rx_div_reg != 16'h0000) begin
      rx_div_next = rx_div_reg - 16'h0001;
    end else begin
      rx_div_next = baud_reg;
      rx_bits_next = rx_bits_reg - 4'h1;
      if (rx_bits_reg == `SPPF_RX_BITS) begin
        if (sync2_reg) begin
          rx_bits_next = 4'h0; // start glitch
        end
      end else if (rx_bits_reg == `SPPF_LAST_BIT) begin
        rx_pulse_next = sync2_reg;
        rx_byte_next = rx_sh_reg;
      end else begin
        rx_sh_next = {sync2_reg, rx_sh_reg[7:1]};
      end
    end
  end

  // uart receiver and line synchroniser: storage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_reg <= 1'b1;
      sync2_reg <= 1'b1;
      rx_bits_reg <= 4'h0;
      rx_div_reg <= 16'h0000;
      rx_sh_reg <= 8'h00;
      rx_byte_reg <= 8'h00;
      rx_pulse_reg <= 1'b0;
    end else if (pce) begin
      sync1_reg <= line_in;
      sync2_reg <= sync1_reg;
      rx_bits_reg <= rx_bits_next;
      rx_div_reg <= rx_div_next;
      rx_sh_reg <= rx_sh_next;
      rx_byte_reg <= rx_byte_next;
      rx_pulse_reg <= rx_pulse_next;
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_ack_modes: assert property (seq_reg == SQ_ACK |->
    (mode == SPPF_R3964 || mode == SPPF_USS || mode == SPPF_MODBUS))
    else $error("ack wait in a mode without acknowledge");
  chk_bcast_no_wait: assert property (
    pce && seq_reg == SQ_POST && tx_idle && idx_reg == `SPPF_SLOT_END &&
    bcast_reg |=> seq_reg == SQ_IDLE)
    else $error("broadcast waited for a response");
  chk_len_reject: assert property (
    pce && seq_reg == SQ_DATA && mode == SPPF_R3964 && txh_vld_reg &&
    tx_idle && cnt_reg == `SPPF_MAX_3964 |-> !send ##1 stat_reg[`SPPF_ST_LEN])
    else $error("256th 3964R byte not rejected");
  chk_low_char: assert property (
    seq_reg == SQ_DATA && mode == SPPF_IDS && txh_reg < `SPPF_PAY_MIN |->
    !send) else $error("control character sent as payload");
  chk_width_range: assert property (
    seq_reg == SQ_DATA && mode == SPPF_IDS && ctrl_reg[5:4] == `SPPF_W6 &&
    txh_reg > `SPPF_PAY_MAX6 |-> !send)
    else $error("character beyond 6-bit range sent");
  chk_id_slot: assert property (
    send && seq_reg != SQ_DATA && mode == SPPF_IDS |->
    send_byte >= `SPPF_ID_MIN && send_byte <= `SPPF_ID_MAX)
    else $error("absent or invalid identifier sent");
  chk_uss_start: assert property (
    send && seq_reg == SQ_PRE && mode == SPPF_USS |->
    send_byte == `SPPF_USS_STX) else $error("USS frame without 02h start");
  chk_uss_bcast: assert property (
    pce && send && seq_reg == SQ_DATA && mode == SPPF_USS && !dup_reg &&
    cnt_reg == `SPPF_USS_ADR_IDX && send_byte[`SPPF_USS_BC_BIT] |=>
    bcast_reg) else $error("USS broadcast bit not honoured");
  chk_yield: assert property (
    pce && seq_reg == SQ_CONN && rx_pulse_reg && !ctrl_reg[6] &&
    rx_byte_reg == `SPPF_STX |=> seq_reg == SQ_IDLE &&
    stat_reg[`SPPF_ST_YIELD]) else $error("low priority did not back off");
  chk_drive_pair: assert property (
    rts_reg == !line_oe_n_reg && (!line_oe_n_reg || line_out_reg))
    else $error("line driver state inconsistent");
  cov_ack_ok: cover property (seq_reg == SQ_ACK && ev_ok);
  cov_timeout: cover property (seq_reg == SQ_ACK && ev_fail);
  cov_yield: cover property (ev_yield);
  cov_bcast: cover property (seq_reg == SQ_POST && bcast_reg);
endmodule : sppf_host_ctrl

/* bench/sppf_partner.sv */
// remote serial station model: byte decoder and answer sender
module sppf_partner #(
  parameter int BIT = 4
) (
  // line side
  input wire logic pclk,
  input wire logic line_out,
  input wire logic line_oe_n,
  output logic line_in
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] got[$];
  initial line_in = 1'b1;
  // decode characters only while the controller drives
  always begin : rx_proc
    logic [7:0] b;
    @(negedge line_out iff !line_oe_n);
    repeat (BIT / 2) @(posedge pclk);
    for (int i = 0; i < 9; i++) begin
      repeat (BIT) @(posedge pclk);
      if (i < 8) b[i] = line_out;
    end
    got.push_back(b);
  end
  // answer one character, lsb first, back to mark
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      line_in <= f[i];
      repeat (BIT) @(posedge pclk);
    end
  endtask : send
endmodule : sppf_partner

/* bench/sppf_host_ctrl_tb.sv */
// self-checking bench of the serial partner controller
module sppf_host_ctrl_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic pclk, presetn, pce, psel, penable, pwrite, pready, pslverr, er;
  logic line_in, line_out, line_oe_n, rts;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  int num_errors, cmp_count;
  // design and remote station
  sppf_host_ctrl dut_u (.pclk(pclk), .presetn(presetn), .pce(pce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .line_in(line_in), .line_out(line_out), .line_oe_n(line_oe_n),
    .rts(rts));
  sppf_partner #(.BIT(4)) p_u (.pclk(pclk), .line_out(line_out),
    .line_oe_n(line_oe_n), .line_in(line_in));
  initial begin : clk_gen
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  // compare and count
  task automatic chk(input logic [31:0] g, input logic [31:0] e,
                     input string m);
    cmp_count++;
    if (g !== e) begin
      num_errors++;
      $display("CHECK FAILED t=%0t %s", $time, m);
    end
  endtask : chk
  task automatic results();
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : results
  // one apb transfer, held until pready
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      num_errors++;
      results();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // write a send byte once the holding slot is free
  task automatic put(input logic [31:0] d);
    int k;
    k = 0;
    do begin
      apb(1'b0, 8'h10, 32'h0);
      k++;
    end while (rd[8] !== 1'b0 && k < 200);
    apb(1'b1, 8'h10, d);
    chk(32'(er), 32'h0, "tx write");
  endtask : put
  // wait for a whole frame and the line release, then compare it
  task automatic frame(input logic [7:0] e[$], input string m);
    int k;
    k = 0;
    while ((p_u.got.size() < e.size() || line_oe_n !== 1'b1) && k < 4000) begin
      @(posedge pclk);
      k++;
    end
    if (k >= 4000) begin
      num_errors++;
      results();
    end
    foreach (e[i]) chk(32'(p_u.got[i]), 32'(e[i]), m);
    p_u.got.delete();
  endtask : frame
  task automatic poll(input int b);
    for (int k = 0; k < 100; k++) begin
      apb(1'b0, 8'h18, 32'h0);
      if (rd[b] === 1'b1) break;
    end
    chk(32'(rd[b]), 32'h1, "status flag");
  endtask : poll
  task automatic t_regs();
    apb(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h30, "ctrl reset");
    apb(1'b0, 8'h04, 32'h0);
    chk(rd, 32'hFFFFFFFF, "ids reset");
    apb(1'b0, 8'h1C, 32'h0);
    chk(32'(er), 32'h1, "unmapped");
    apb(1'b1, 8'h08, 32'h3);
    apb(1'b1, 8'h0C, 32'hC8);
  endtask : t_regs
  task automatic t_frames();
    put(32'h1A5);
    frame({8'hA5}, "raw");
    apb(1'b1, 8'h00, 32'h31);
    apb(1'b1, 8'h04, 32'hFF03FF02);
    put(32'h141);
    frame({8'h02, 8'h41, 8'h03}, "id frame");
    put(32'h105);
    frame({8'h02, 8'h03}, "id drop");
    poll(2);
    apb(1'b1, 8'h00, 32'h33);
    put(32'h05);
    put(32'h101);
    frame({8'h02, 8'h05, 8'h01, 8'h06}, "uss");
    p_u.send(8'h02);
    poll(0);
  endtask : t_frames
  // 3964R handshake, back-off, length limit, Modbus broadcast and timeout
  task automatic t_proto();
    apb(1'b0, 8'h14, 32'h0);
    chk(rd, 32'h102, "rx byte");
    apb(1'b1, 8'h18, 32'h3F);
    apb(1'b1, 8'h00, 32'h32);
    put(32'h10);
    frame({8'h02}, "stx");
    p_u.send(8'h02);
    poll(5);
    frame({8'h02}, "retry");
    p_u.send(8'h10);
    put(32'h141);
    frame({8'h10, 8'h10, 8'h41, 8'h10, 8'h03, 8'h52}, "3964");
    p_u.send(8'h10);
    poll(0);
    apb(1'b1, 8'h00, 32'h72);
    put(32'h20);
    frame({8'h02}, "stx hi");
    p_u.send(8'h10);
    for (int i = 0; i < 254; i++) put(32'h20);
    put(32'h120);
    poll(3);
    chk(32'(p_u.got.size()), 32'h0FF, "3964 length");
    p_u.got.delete();
    apb(1'b1, 8'h18, 32'h3F);
    apb(1'b1, 8'h00, 32'h34);
    put(32'h00);
    put(32'h103);
    frame({8'h00, 8'h03}, "bcast");
    repeat (8) @(posedge pclk);
    apb(1'b0, 8'h18, 32'h0);
    chk(rd & 32'h103, 32'h0, "no wait");
    put(32'h105);
    frame({8'h05}, "request");
    poll(1);
  endtask : t_proto
  initial begin : main
    num_errors = 0;
    cmp_count = 0;
    presetn = 1'b0;
    pce = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_frames();
    t_proto();
    results();
  end
endmodule : sppf_host_ctrl_tb
